/* File: hdl/rdml_top.sv */
// reset debug-mode latch, reset sequencing and pin-state control with ahb-lite registers
// assumes pins other than RESET_N and BREAKPOINT_REQUEST_N (two-flop synchronised) are synchronous to CLK and one ahb-lite master owns the bus
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`include "rdml_consts.svh"
module rdml_top
    import rdml_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic RESET_N,
    input wire logic BREAKPOINT_REQUEST_N,
    input wire logic INTERNAL_BREAKPOINT,
    input wire logic [`RDML_PINS-1:0] PIN_IN,
    input wire logic [`RDML_PINS-1:0] MOD_OUT,
    input wire logic [`RDML_PINS-1:0] MOD_OE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic DEBUG_ENABLE,
    output logic ENTER_DEBUG,
    output logic BREAKPOINT_EXCEPTION,
    output logic BUS_START,
    output logic RUNNING,
    output logic [`RDML_PINS-1:0] PIN_OUT,
    output logic [`RDML_PINS-1:0] PIN_OE
);
    rdml_regs_t r;
    rdml_regs_t next_r;
    logic in_reset;
    logic release_edge;
    logic brk_event;
    logic take;

    // only the second flop of each synchroniser is looked at
    // reset and breakpoint pins share one depth, so the release sees a coherent level
    assign in_reset = !r.rst_s2;
    assign release_edge = r.rst_s2 && !r.rst_prev;
    // refused while the reset pin is held, also in the one cycle before the
    // state has fallen back to reset, so no pulse leaks out of a new reset
    assign brk_event = (r.st != ST_RESET) && !in_reset && !release_edge &&
        ((!r.brk_s2 && r.brk_prev) || INTERNAL_BREAKPOINT);
    assign take = HSEL && HTRANS[1] && HREADY;

    always_comb begin
        next_r = r;
        next_r.rst_s1 = RESET_N;
        next_r.rst_s2 = r.rst_s1;
        next_r.rst_prev = r.rst_s2;
        // same depth as the reset path so two low cycles line up with the release
        next_r.brk_s1 = BREAKPOINT_REQUEST_N;
        next_r.brk_s2 = r.brk_s1;
        next_r.brk_prev = r.brk_s2;
        next_r.enter_dbg = 1'b0;
        next_r.brk_exc = 1'b0;
        next_r.bus_start = 1'b0;

        // data phase of a write that was taken last cycle
        if (r.a_wr) begin
            case (r.a_idx)
                `RDML_OFF_DIR: next_r.dir = HWDATA[`RDML_PINS-1:0];
                `RDML_OFF_DATA: next_r.data = HWDATA[`RDML_PINS-1:0];
                `RDML_OFF_FUNC: next_r.func = HWDATA[`RDML_PINS-1:0];
                default: next_r.dir = next_r.dir;
            endcase
        end

        case (r.st)
            ST_RESET: begin
                if (release_edge) begin
                    next_r.debug_en = !r.brk_s2;
                    next_r.st = ST_MODE_SEL;
                end
            end
            ST_MODE_SEL: begin
                next_r.cnt = '0;
                next_r.st = ST_WAIT;
            end
            // counted from the detected release, so the pin's synchroniser lag
            // adds to the delay that the outside world sees
            ST_WAIT: begin
                next_r.cnt = r.cnt + 4'h1;
                if (r.cnt == `RDML_WAIT_LAST) begin
                    next_r.st = ST_RUN;
                    next_r.bus_start = 1'b1;
                end
            end
            ST_RUN: next_r.st = ST_RUN;
            default: next_r.st = ST_RESET;
        endcase

        if (brk_event) begin
            next_r.enter_dbg = r.debug_en;
            next_r.brk_exc = !r.debug_en;
        end

        // reset held: no function owns a pin, all ports are inputs
        if (in_reset) begin
            next_r.st = ST_RESET;
            next_r.cnt = '0;
            next_r.dir = `RDML_PIN_RST;
            next_r.data = `RDML_PIN_RST;
            next_r.func = `RDML_PIN_RST;
            next_r.enter_dbg = 1'b0;
            next_r.brk_exc = 1'b0;
            next_r.bus_start = 1'b0;
        end

        // drivers stay off until the release, then follow function or port direction
        for (int i = 0; i < `RDML_PINS; i++) begin
            next_r.pin_out[i] = next_r.func[i] ? MOD_OUT[i] : next_r.data[i];
            next_r.pin_oe[i] = (next_r.st != ST_RESET) &&
                (next_r.func[i] ? MOD_OE[i] : next_r.dir[i]);
        end
        // kept in a flop of its own so the output has no decode behind it
        next_r.running = (next_r.st == ST_RUN);

        next_r.a_wr = take && HWRITE;
        if (take) begin
            next_r.a_idx = HADDR[3:2];
        end
        // direction, data and function reads take next values so a write just before is seen
        next_r.hrdata = 32'h0000_0000;
        if (take && !HWRITE && HADDR[31:`RDML_ADDR_W] == '0) begin
            case (HADDR[3:2])
                `RDML_OFF_DIR: next_r.hrdata[`RDML_PINS-1:0] = next_r.dir;
                `RDML_OFF_DATA: next_r.hrdata[`RDML_PINS-1:0] = next_r.data;
                `RDML_OFF_FUNC: next_r.hrdata[`RDML_PINS-1:0] = next_r.func;
                `RDML_OFF_STAT: begin
                    next_r.hrdata[`RDML_BIT_DEBUG] = r.debug_en;
                    next_r.hrdata[`RDML_BIT_RUN] = (r.st == ST_RUN);
                    next_r.hrdata[`RDML_BIT_PIN_LO +: `RDML_PINS] = PIN_IN;
                end
                default: next_r.hrdata = 32'h0000_0000;
            endcase
        end
        if (take && HADDR[31:`RDML_ADDR_W] != '0) begin
            next_r.a_wr = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            r <= '0;
        end else if (CE) begin
            r <= next_r;
        end
    end

    assign HRDATA = r.hrdata;
    // zero-wait slave; the word lands the cycle after it is offered
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign DEBUG_ENABLE = r.debug_en;
    assign ENTER_DEBUG = r.enter_dbg;
    assign BREAKPOINT_EXCEPTION = r.brk_exc;
    assign BUS_START = r.bus_start;
    assign RUNNING = r.running;
    assign PIN_OUT = r.pin_out;
    assign PIN_OE = r.pin_oe;

    sequence s_release;
        CE && release_edge;
    endsequence

    sequence s_break;
        CE && brk_event;
    endsequence

    // one clean wait cycle: clock running and the reset pin still released
    sequence s_wait_clear;
        CE && !in_reset;
    endsequence

    a_latch_level: assert property (@(posedge CLK) disable iff (RST)
        s_release |=> DEBUG_ENABLE == !$past(r.brk_s2))
        else $error("debug enable not latched from breakpoint level");

    a_enable_hold: assert property (@(posedge CLK) disable iff (RST)
        !(CE && release_edge) |=> $stable(DEBUG_ENABLE))
        else $error("debug enable changed without a release");

    a_debug_entry: assert property (@(posedge CLK) disable iff (RST)
        (s_break and DEBUG_ENABLE) |=> ENTER_DEBUG && !BREAKPOINT_EXCEPTION)
        else $error("breakpoint did not enter debug mode");

    a_exc_entry: assert property (@(posedge CLK) disable iff (RST)
        (s_break and !DEBUG_ENABLE) |=> BREAKPOINT_EXCEPTION && !ENTER_DEBUG)
        else $error("breakpoint did not raise an exception");

    a_reset_hiz: assert property (@(posedge CLK) disable iff (RST)
        (r.st == ST_RESET) |-> PIN_OE == '0)
        else $error("pin driven while reset held");

    a_ports_clear: assert property (@(posedge CLK) disable iff (RST)
        (CE && in_reset) |=> r.dir == '0 && r.func == '0 && r.st == ST_RESET)
        else $error("port direction or function not cleared");

    a_mode_first: assert property (@(posedge CLK) disable iff (RST)
        s_release |=> r.st == ST_MODE_SEL && !RUNNING)
        else $error("mode selection did not follow release");

    a_bus_ten: assert property (@(posedge CLK) disable iff (RST)
        (s_release ##1 s_wait_clear [*8] ##1 s_wait_clear) |=> BUS_START && RUNNING)
        else $error("first bus cycle not ten clocks after release");

    a_bus_once: assert property (@(posedge CLK) disable iff (RST)
        BUS_START |-> $past(r.st) == ST_WAIT && $past(r.cnt) == `RDML_WAIT_LAST)
        else $error("bus start outside the wait window");

    a_port_owner: assert property (@(posedge CLK) disable iff (RST)
        (CE && !in_reset && r.st == ST_RUN) |=>
        (PIN_OE & ~r.func) == (r.dir & ~r.func))
        else $error("port pin drive does not follow direction");

    a_sync_edge: assert property (@(posedge CLK) disable iff (RST)
        s_release |-> $past(r.rst_s2) == 1'b0 || !$past(CE))
        else $error("release seen without a rising synchronised reset");
endmodule

/* File: hdl/rdml_consts.svh */
// constants for the reset debug-mode latch and pin-state logic
// assumes one synchronous clock domain and a 32-bit ahb-lite register port
// Overview of operation
// - sample breakpoint at release; low enables debug
// - enabled debug: breakpoints enter background debug mode
// - breakpoint high at release: breakpoints raise exceptions
// - enable held until next reset, relatched each release
// - breakpoint synchronised; hold low two cycles before
// - reset clears pin functions and port directions
// - pins high-impedance while reset is held
// - mode select, then exception processing; outputs after
// - port pins high-z; others follow control registers
// - first bus cycle ten clocks after release
`ifndef RDML_CONSTS_SVH
`define RDML_CONSTS_SVH
`define RDML_PINS 8
`define RDML_CNT_W 4
`define RDML_FIRST_BUS_CYCLES 4'ha
`define RDML_WAIT_LAST (`RDML_FIRST_BUS_CYCLES - 4'h3)
`define RDML_OFF_DIR 2'h0
`define RDML_OFF_DATA 2'h1
`define RDML_OFF_FUNC 2'h2
`define RDML_OFF_STAT 2'h3
`define RDML_ADDR_W 4
`define RDML_PIN_RST 8'h00
`define RDML_BIT_DEBUG 0
`define RDML_BIT_RUN 1
`define RDML_BIT_PIN_LO 8
`endif

/* File: hdl/rdml_pkg.sv */
// types for the reset debug-mode latch and pin-state logic
// assumes the constants header is on the include path
`include "rdml_consts.svh"
package rdml_pkg;
    typedef enum logic [1:0] {ST_RESET, ST_MODE_SEL, ST_WAIT, ST_RUN} rdml_state_t;
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic rst_prev;
        logic brk_s1;
        logic brk_s2;
        logic brk_prev;
        rdml_state_t st;
        logic [`RDML_CNT_W-1:0] cnt;
        logic debug_en;
        logic enter_dbg;
        logic brk_exc;
        logic bus_start;
        logic running;
        logic [`RDML_PINS-1:0] dir;
        logic [`RDML_PINS-1:0] data;
        logic [`RDML_PINS-1:0] func;
        logic [`RDML_PINS-1:0] pin_out;
        logic [`RDML_PINS-1:0] pin_oe;
        logic a_wr;
        logic [1:0] a_idx;
        logic [31:0] hrdata;
    } rdml_regs_t;
endpackage

/* File: tb/rdml_host.sv */
// host model: drives reset and breakpoint pins, pulls up undriven pins
// assumes go is a one-cycle pulse from the bench
module rdml_host
    import rdml_pkg::*;
(
    input wire logic clk,
    input wire logic go,
    input wire logic want_dbg,
    input wire logic brk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic reset_n,
    output logic brk_n,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    always @(posedge clk) begin
        if (go) begin
            cnt <= 4'h1;
        end else if (cnt != 4'h0) begin
            cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
        end
    end
    assign reset_n = !(cnt != 4'h0 && cnt <= 4'h5);
    // low 5 cycles before negation, let go 2 after, long before the first bus cycle
    assign brk_n = !(brk || (want_dbg && cnt != 4'h0 && cnt <= 4'h7));
    // pull-up on pins nobody drives
    assign pin_in = (pin_oe & pin_out) | ~pin_oe;
endmodule

/* File: tb/reset_debug_mode_latch_pin_states_test.sv */
// self-checking bench for the reset debug-mode latch and pin states
// assumes rdml_host supplies the reset and breakpoint pins
module reset_debug_mode_latch_pin_states_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, go = 0, dbg = 0, brk = 0, ibk = 0, hsel = 0, hwrite = 0;
    logic rstn, bkn, hready, hresp, den, ent, exc, bst, run;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [7:0] mout = 8'h99, moe = 8'hF0, pout, poe, pin;
    // address, write data, expected read back
    logic [23:0] rows [4] = '{24'h00_A5A5, 24'h04_3C3C, 24'h08_0F0F, 24'h10_FF00};
    int err_count = 0, tests_run = 0;
    always #5 clk = ~clk;
    rdml_host host (.clk(clk), .go(go), .want_dbg(dbg), .brk(brk), .pin_out(pout),
        .pin_oe(poe), .reset_n(rstn), .brk_n(bkn), .pin_in(pin));
    rdml_top dut (.CLK(clk), .RST(rst), .CE(1'b1), .RESET_N(rstn), .BREAKPOINT_REQUEST_N(bkn),
        .INTERNAL_BREAKPOINT(ibk), .PIN_IN(pin), .MOD_OUT(mout), .MOD_OE(moe), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .DEBUG_ENABLE(den), .ENTER_DEBUG(ent), .BREAKPOINT_EXCEPTION(exc), .BUS_START(bst),
        .RUNNING(run), .PIN_OUT(pout), .PIN_OE(poe));
    task automatic results();
        $display("errors %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (hready === 1'b1 && htrans == 2'h2) begin
                htrans <= 2'h0;
                hsel <= 1'b0;
                hwdata <= wd;
            end else if (hready === 1'b1) begin
                rd = hrdata;
                return;
            end
        end
        check(0, 1, "bus timeout");
        results();
    endtask
    task automatic pulse_reset(input logic d, input logic den_old);
        int i;
        dbg <= d;
        go <= 1'b1;
        for (i = 1; i < 40; i++) begin
            @(posedge clk);
            go <= 1'b0;
            #1;
            if (i == 6) begin
                check(poe, 8'h0, "pin drive in reset");
                check(den, den_old, "debug enable held");
                check(run, 0, "running in reset");
            end
            if (bst === 1'b1) break;
        end
        // 6 host cycles to release, 2 sync edges, then 10 to the first bus cycle
        check(i, 18, "bus start delay");
        if (i == 40) results();
        check(den, d, "debug enable latch");
        @(posedge clk);
        #1;
        check({bst, run}, 2'b01, "bus start pulse, running");
    endtask
    task automatic brk_test(input logic pin, input logic en);
        logic [7:0] nd, ne;
        nd = 8'h0;
        ne = 8'h0;
        if (pin) brk <= 1'b1;
        else ibk <= 1'b1;
        // a pin held low must give exactly one event
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            ibk <= 1'b0;
            #1;
            nd = nd + {7'h0, ent};
            ne = ne + {7'h0, exc};
        end
        brk <= 1'b0;
        check({nd, ne}, en ? 32'h100 : 32'h1, "breakpoint routing");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        pulse_reset(1'b1, 1'b0);
        for (int r = 0; r < 4; r++) begin
            ahb(1'b1, {24'h0, rows[r][23:16]}, {24'h0, rows[r][15:8]});
            ahb(1'b0, {24'h0, rows[r][23:16]}, 32'h0);
            check(rd, {24'h0, rows[r][7:0]}, "register read back");
        end
        check({poe, pout}, 16'hA039, "pin drive from registers");
        ahb(1'b0, 32'hC, 32'h0);
        check(rd, 32'h7F03, "status");
        brk_test(1'b1, 1'b1);
        brk_test(1'b0, 1'b1);
        pulse_reset(1'b0, 1'b1);
        ahb(1'b0, 32'h0, 32'h0);
        check({hresp, rd[7:0], poe}, 17'h0, "port inputs after reset");
        brk_test(1'b1, 1'b0);
        brk_test(1'b0, 1'b0);
        results();
    end
endmodule
